// ==== exposure_trigger_pkg.sv ====
package exposure_trigger_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SW_TRIG = 8'h04;
  localparam logic [7:0] REG_EXPOSURE = 8'h08;
  localparam logic [7:0] REG_RD_DELAY = 8'h0C;
  localparam logic [7:0] REG_ROI_OFFSET = 8'h10;
  localparam logic [7:0] REG_ROI_SIZE = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_TEMP = 8'h1C;
  localparam logic [7:0] REG_TEMP_LIMIT = 8'h20;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h24;
  localparam logic [7:0] REG_IRQ_MASK = 8'h28;
  localparam logic [7:0] REG_LUT_ADDR = 8'h2C;
  localparam logic [7:0] REG_LUT_DATA = 8'h30;

  // control field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_LUT_BIT = 1;
  localparam int CTRL_ROI_BIT = 2;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_W = 4;

  // interrupt field positions
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_EXP_BIT = 1;
  localparam int IRQ_TEMP_BIT = 2;
  localparam int IRQ_W = 3;

  // window fields: low half and high half of a word
  localparam int ROI_LO_POS = 0;
  localparam int ROI_HI_POS = 16;
  localparam int COORD_W = 12;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [31:0] EXPOSURE_RST = 32'h0000_2710;
  localparam logic [31:0] RD_DELAY_RST = 32'h0000_0000;
  localparam logic [COORD_W-1:0] ROI_RST = 12'h000;
  localparam logic [COORD_W-1:0] TEMP_LIMIT_RST = 12'hC00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // sample depths
  localparam int ADC_W = 12;
  localparam int OUT_W = 8;

  // window limits and step masks
  localparam logic [COORD_W-1:0] ROI_MIN_W = 12'h080;
  localparam logic [COORD_W-1:0] ROI_MIN_H = 12'h002;
  localparam logic [COORD_W-1:0] ROI_MASK_W8 = 12'hFF8;
  localparam logic [COORD_W-1:0] ROI_MASK_W12 = 12'hFF0;
  localparam logic [COORD_W-1:0] ROI_MASK_H = 12'hFFE;
  localparam logic [COORD_W-1:0] ROI_MASK_X = 12'hFF8;
  localparam logic [COORD_W-1:0] ROI_MASK_Y = 12'hFFE;

  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TRIG_LATENCY_NS = 20;
  localparam logic [31:0] TRIG_LATENCY_CYC = 32'((TRIG_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int LED_HALF_MS = 250;
  localparam int LED_HALF_CYC = LED_HALF_MS * (1000000000 / CLK_PERIOD_PS);

  typedef enum logic [1:0] {EXP_IDLE, EXP_ALIGN, EXP_LATENCY, EXP_ON} exp_state_t;
  typedef enum logic [1:0] {RD_IDLE, RD_DELAY, RD_LINE, RD_GAP} rd_state_t;

endpackage

// ==== exposure_trigger_readout.sv ====
`timescale 1ns/1ps
module exposure_trigger_readout #(
  parameter logic [11:0] SENSOR_COLS = 12'h800,
  parameter logic [11:0] SENSOR_ROWS = 12'h600,
  parameter logic [11:0] LINE_GAP = 12'h010,
  parameter int unsigned LED_HALF_CYCLES = exposure_trigger_pkg::LED_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [exposure_trigger_pkg::ADDR_W-1:0] i_addr,
  input wire logic [exposure_trigger_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [exposure_trigger_pkg::DATA_W-1:0] o_rd_data,
  input wire logic i_trigger,
  input wire logic [exposure_trigger_pkg::ADC_W-1:0] i_pix_data,
  input wire logic [exposure_trigger_pkg::COORD_W-1:0] i_temp,
  output logic o_exposing,
  output logic o_sensor_read,
  output logic [exposure_trigger_pkg::COORD_W-1:0] o_sensor_row,
  output logic [exposure_trigger_pkg::COORD_W-1:0] o_sensor_col,
  output logic o_line_valid,
  output logic o_frame_valid,
  output logic [exposure_trigger_pkg::ADC_W-1:0] o_pix_data,
  output logic o_led_red,
  output logic o_irq
);
  import exposure_trigger_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [CTRL_W-1:0] ctrl;
  logic sw_trig;
  logic [31:0] exposure;
  logic [31:0] rd_delay;
  logic [COORD_W-1:0] roi_x_raw, roi_y_raw, roi_w_raw, roi_h_raw;
  logic [COORD_W-1:0] temp, temp_limit;
  logic over_temp, over_temp_q;
  logic [IRQ_W-1:0] irq_status, irq_mask;
  logic [ADC_W-1:0] lut_addr;
  logic [OUT_W-1:0] lut [0:(1<<ADC_W)-1];
  logic [31:0] led_cnt;

  exp_state_t exp_state;
  rd_state_t rd_state;
  logic [31:0] exp_cnt;
  logic [31:0] rd_cnt;
  logic rd_req;
  logic trig_q;
  logic exposing_q;
  logic [COORD_W-1:0] fr_x, fr_w, col_left, row_left, gap_cnt;
  logic fv0, lv1, fv1, lv_out_q, fv_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode and selection

  wire sel_ctrl = (i_addr == REG_CTRL);
  wire sel_sw_trig = (i_addr == REG_SW_TRIG);
  wire sel_exposure = (i_addr == REG_EXPOSURE);
  wire sel_rd_delay = (i_addr == REG_RD_DELAY);
  wire sel_roi_off = (i_addr == REG_ROI_OFFSET);
  wire sel_roi_size = (i_addr == REG_ROI_SIZE);
  wire sel_status = (i_addr == REG_STATUS);
  wire sel_temp = (i_addr == REG_TEMP);
  wire sel_temp_limit = (i_addr == REG_TEMP_LIMIT);
  wire sel_irq_status = (i_addr == REG_IRQ_STATUS);
  wire sel_irq_mask = (i_addr == REG_IRQ_MASK);
  wire sel_lut_addr = (i_addr == REG_LUT_ADDR);
  wire sel_lut_data = (i_addr == REG_LUT_DATA);
  wire wr_lut_data = i_wr && sel_lut_data;

  wire mode_trig = ctrl[CTRL_MODE_BIT];
  wire lut_en = ctrl[CTRL_LUT_BIT];
  wire roi_en = ctrl[CTRL_ROI_BIT];
  wire run = ctrl[CTRL_RUN_BIT];

  // 8-bit output when the table is on, so the narrower width step applies
  wire [COORD_W-1:0] w_mask = lut_en ? ROI_MASK_W8 : ROI_MASK_W12;
  wire [COORD_W-1:0] w_step = roi_w_raw & w_mask;
  wire [COORD_W-1:0] h_step = roi_h_raw & ROI_MASK_H;
  wire [COORD_W-1:0] win_x = roi_en ? (roi_x_raw & ROI_MASK_X) : '0;
  wire [COORD_W-1:0] win_y = roi_en ? (roi_y_raw & ROI_MASK_Y) : '0;
  wire [COORD_W-1:0] win_w = !roi_en ? SENSOR_COLS : (w_step < ROI_MIN_W) ? ROI_MIN_W : w_step;
  wire [COORD_W-1:0] win_h = !roi_en ? SENSOR_ROWS : (h_step < ROI_MIN_H) ? ROI_MIN_H : h_step;

  wire trig = i_trigger | sw_trig;
  wire trig_rise = trig & ~trig_q;
  wire lv_fall = lv_out_q & ~o_line_valid;

  wire [OUT_W-1:0] lut_out = lut[i_pix_data];
  wire [ADC_W-1:0] mapped = lut_en ? {{(ADC_W-OUT_W){1'b0}}, lut_out} : i_pix_data;

  // a pending readout request counts as busy, so a status poll never sees a false idle
  wire [31:0] status_word = {26'h0, over_temp, o_frame_valid, o_line_valid, o_exposing,
                             (rd_state != RD_IDLE || rd_req), (exp_state != EXP_IDLE)};

  wire [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_FRAME_BIT] = fv_out_q & ~o_frame_valid;
  assign irq_set[IRQ_EXP_BIT] = o_exposing & ~exposing_q;
  assign irq_set[IRQ_TEMP_BIT] = over_temp & ~over_temp_q;
  wire [IRQ_W-1:0] irq_clr = (i_wr && sel_irq_status) ? i_wr_data[IRQ_W-1:0] : '0;
  // set wins over a clear landing in the same cycle
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

  wire [31:0] rd_value =
    sel_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl} :
    sel_sw_trig ? {31'h0, sw_trig} :
    sel_exposure ? exposure :
    sel_rd_delay ? rd_delay :
    sel_roi_off ? {4'h0, roi_y_raw, 4'h0, roi_x_raw} :
    sel_roi_size ? {4'h0, roi_h_raw, 4'h0, roi_w_raw} :
    sel_status ? status_word :
    sel_temp ? {20'h0, temp} :
    sel_temp_limit ? {20'h0, temp_limit} :
    sel_irq_status ? {{(32-IRQ_W){1'b0}}, irq_status} :
    sel_irq_mask ? {{(32-IRQ_W){1'b0}}, irq_mask} :
    sel_lut_addr ? {20'h0, lut_addr} :
    sel_lut_data ? {24'h0, lut[lut_addr]} :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl <= CTRL_RST;
      sw_trig <= 1'b0;
      exposure <= EXPOSURE_RST;
      rd_delay <= RD_DELAY_RST;
      roi_x_raw <= ROI_RST;
      roi_y_raw <= ROI_RST;
      roi_w_raw <= ROI_RST;
      roi_h_raw <= ROI_RST;
      temp_limit <= TEMP_LIMIT_RST;
      irq_mask <= IRQ_RST;
      irq_status <= IRQ_RST;
      lut_addr <= '0;
      o_rd_data <= '0;
      o_irq <= 1'b0;
    end else begin
      if (i_wr && sel_ctrl) ctrl <= i_wr_data[CTRL_W-1:0];
      if (i_wr && sel_sw_trig) sw_trig <= i_wr_data[0];
      if (i_wr && sel_exposure) exposure <= i_wr_data;
      if (i_wr && sel_rd_delay) rd_delay <= i_wr_data;
      if (i_wr && sel_roi_off) begin
        roi_x_raw <= i_wr_data[ROI_LO_POS +: COORD_W];
        roi_y_raw <= i_wr_data[ROI_HI_POS +: COORD_W];
      end
      if (i_wr && sel_roi_size) begin
        roi_w_raw <= i_wr_data[ROI_LO_POS +: COORD_W];
        roi_h_raw <= i_wr_data[ROI_HI_POS +: COORD_W];
      end
      if (i_wr && sel_temp_limit) temp_limit <= i_wr_data[COORD_W-1:0];
      if (i_wr && sel_irq_mask) irq_mask <= i_wr_data[IRQ_W-1:0];
      if (i_wr && sel_lut_addr) begin
        lut_addr <= i_wr_data[ADC_W-1:0];
      end else if (wr_lut_data) begin
        lut_addr <= lut_addr + 1'b1;
      end
      irq_status <= next_irq_status;
      o_irq <= |(next_irq_status & irq_mask);
      o_rd_data <= i_rd ? rd_value : '0;
    end
  end

  // table contents are not reset: software loads a curve before enabling it
  always_ff @(posedge i_clk_sys) begin
    if (wr_lut_data) lut[lut_addr] <= i_wr_data[OUT_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // exposure control

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      exp_state <= EXP_IDLE;
      exp_cnt <= '0;
      o_exposing <= 1'b0;
      rd_req <= 1'b0;
      trig_q <= 1'b0;
      exposing_q <= 1'b0;
    end else begin
      trig_q <= trig;
      exposing_q <= o_exposing;
      rd_req <= 1'b0;
      case (exp_state)
        EXP_IDLE: begin
          if (run && mode_trig) begin
            if (trig_rise && o_frame_valid) begin
              exp_state <= EXP_ALIGN;
            end else if (trig_rise) begin
              exp_cnt <= TRIG_LATENCY_CYC;
              exp_state <= EXP_LATENCY;
            end
          end else if (run && rd_state == RD_IDLE && !rd_req) begin
            if (exposure == 32'h0000_0000) begin
              rd_req <= 1'b1;
            end else begin
              exp_cnt <= exposure;
              o_exposing <= 1'b1;
              exp_state <= EXP_ON;
            end
          end
        end
        EXP_ALIGN: begin
          if (!trig) begin
            exp_state <= EXP_IDLE;
          end else if (lv_fall || !o_frame_valid) begin
            o_exposing <= 1'b1;
            exp_state <= EXP_ON;
          end
        end
        EXP_LATENCY: begin
          if (!trig) begin
            exp_state <= EXP_IDLE;
          end else if (exp_cnt <= 32'h0000_0001) begin
            o_exposing <= 1'b1;
            exp_state <= EXP_ON;
          end else begin
            exp_cnt <= exp_cnt - 32'h0000_0001;
          end
        end
        EXP_ON: begin
          // pulse mode: the trigger (pin or software bit) alone decides the length of each exposure
          if (mode_trig ? !trig : (exp_cnt <= 32'h0000_0001)) begin
            o_exposing <= 1'b0;
            rd_req <= 1'b1;
            exp_state <= EXP_IDLE;
          end else begin
            exp_cnt <= exp_cnt - 32'h0000_0001;
          end
        end
        default: exp_state <= EXP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readout sequencing, one pixel per clock

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_state <= RD_IDLE;
      rd_cnt <= '0;
      o_sensor_read <= 1'b0;
      o_sensor_row <= '0;
      o_sensor_col <= '0;
      fv0 <= 1'b0;
      fr_x <= '0;
      fr_w <= '0;
      col_left <= '0;
      row_left <= '0;
      gap_cnt <= '0;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          // a request that meets a running frame is dropped; pulse mode relies on the
          // trigger falling only once frame_valid is low
          if (rd_req && rd_delay == 32'h0000_0000) begin
            fr_x <= win_x;
            fr_w <= win_w;
            o_sensor_col <= win_x;
            o_sensor_row <= win_y;
            col_left <= win_w;
            row_left <= win_h;
            o_sensor_read <= 1'b1;
            fv0 <= 1'b1;
            rd_state <= RD_LINE;
          end else if (rd_req) begin
            rd_cnt <= rd_delay;
            rd_state <= RD_DELAY;
          end
        end
        RD_DELAY: begin
          if (rd_cnt <= 32'h0000_0001) begin
            fr_x <= win_x;
            fr_w <= win_w;
            o_sensor_col <= win_x;
            o_sensor_row <= win_y;
            col_left <= win_w;
            row_left <= win_h;
            o_sensor_read <= 1'b1;
            fv0 <= 1'b1;
            rd_state <= RD_LINE;
          end else begin
            rd_cnt <= rd_cnt - 32'h0000_0001;
          end
        end
        RD_LINE: begin
          if (col_left <= 12'h001) begin
            o_sensor_read <= 1'b0;
            if (row_left <= 12'h001) begin
              fv0 <= 1'b0;
              rd_state <= RD_IDLE;
            end else begin
              row_left <= row_left - 12'h001;
              gap_cnt <= LINE_GAP;
              rd_state <= RD_GAP;
            end
          end else begin
            o_sensor_col <= o_sensor_col + 12'h001;
            col_left <= col_left - 12'h001;
          end
        end
        RD_GAP: begin
          if (gap_cnt <= 12'h001) begin
            o_sensor_row <= o_sensor_row + 12'h001;
            o_sensor_col <= fr_x;
            col_left <= fr_w;
            o_sensor_read <= 1'b1;
            rd_state <= RD_LINE;
          end else begin
            gap_cnt <= gap_cnt - 12'h001;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel pipeline: sensor answers one cycle after the address

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lv1 <= 1'b0;
      fv1 <= 1'b0;
      o_line_valid <= 1'b0;
      o_frame_valid <= 1'b0;
      o_pix_data <= '0;
      lv_out_q <= 1'b0;
      fv_out_q <= 1'b0;
    end else begin
      lv1 <= o_sensor_read;
      fv1 <= fv0;
      o_line_valid <= lv1;
      o_frame_valid <= fv1;
      o_pix_data <= lv1 ? mapped : '0;
      lv_out_q <= o_line_valid;
      fv_out_q <= o_frame_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temperature watch

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      temp <= '0;
      over_temp <= 1'b0;
      over_temp_q <= 1'b0;
      led_cnt <= '0;
      o_led_red <= 1'b0;
    end else begin
      temp <= i_temp;
      over_temp <= (temp >= temp_limit);
      over_temp_q <= over_temp;
      if (!over_temp) begin
        led_cnt <= '0;
        o_led_red <= 1'b0;
      end else if (led_cnt >= 32'(LED_HALF_CYCLES - 1)) begin
        led_cnt <= '0;
        o_led_red <= ~o_led_red;
      end else begin
        led_cnt <= led_cnt + 32'h0000_0001;
      end
    end
  end

endmodule // exposure_trigger_readout

// ==== exposure_trigger_sva.sv ====
`timescale 1ns/1ps
module exposure_trigger_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [exposure_trigger_pkg::ADDR_W-1:0] i_addr,
  input wire logic [exposure_trigger_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_trigger,
  input wire logic [exposure_trigger_pkg::COORD_W-1:0] i_temp,
  input wire logic o_exposing,
  input wire logic o_sensor_read,
  input wire logic o_line_valid,
  input wire logic o_frame_valid,
  input wire logic [exposure_trigger_pkg::ADC_W-1:0] o_pix_data,
  input wire logic o_led_red
);
  import exposure_trigger_pkg::*;
  // shadows of the few control bits the properties need, kept from the write port
  logic pulse_on;
  logic sw;
  logic [COORD_W-1:0] limit;
  wire logic trig;
  assign trig = i_trigger | sw;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pulse_on <= 1'b0;
      sw <= 1'b0;
      limit <= TEMP_LIMIT_RST;
    end else if (i_wr) begin
      if (i_addr == REG_CTRL) pulse_on <= i_wr_data[CTRL_MODE_BIT] & i_wr_data[CTRL_RUN_BIT];
      if (i_addr == REG_SW_TRIG) sw <= i_wr_data[0];
      if (i_addr == REG_TEMP_LIMIT) limit <= i_wr_data[COORD_W-1:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_idle_pix_zero: assert property (!o_line_valid |-> o_pix_data == '0)
    else $error("pixel data not zero outside a line");
  a_line_in_frame: assert property (o_line_valid |-> o_frame_valid)
    else $error("line valid outside frame valid");
  a_line_after_read: assert property (o_line_valid == $past(o_sensor_read, 2))
    else $error("line valid not two cycles behind sensor read");
  a_frame_opens_line: assert property ($rose(o_frame_valid) |-> $rose(o_line_valid))
    else $error("frame valid rose without a line start");
  a_frame_closes_line: assert property ($fell(o_frame_valid) |-> $fell(o_line_valid))
    else $error("frame valid fell apart from the last line");
  a_pulse_start_delay: assert property (pulse_on && $rose(trig) && !o_frame_valid && !o_exposing
    |-> !o_exposing[*6] ##[1:2] o_exposing) else $error("exposure start latency wrong");
  a_pulse_fall_ends: assert property (pulse_on && o_exposing && $fell(trig) |-> ##[1:2] !o_exposing)
    else $error("exposure not ended by trigger fall");
  a_led_cool_off: assert property ((i_temp < limit)[*4] |-> !o_led_red)
    else $error("red indicator on below the limit");
endmodule // exposure_trigger_sva

// ==== sensor_array_model.sv ====
`timescale 1ns/1ps
module sensor_array_model (
  input wire logic i_clk_sys,
  input wire logic i_read,
  input wire logic [exposure_trigger_pkg::COORD_W-1:0] i_row,
  input wire logic [exposure_trigger_pkg::COORD_W-1:0] i_col,
  output logic [exposure_trigger_pkg::ADC_W-1:0] o_pix
);
  import exposure_trigger_pkg::*;
  // pixel code carries its own address so a misplaced read shows up
  // when not addressed the data toggles, so stale values never look right
  initial o_pix = 12'h000;
  always @(posedge i_clk_sys) begin
    if (i_read) begin
      o_pix <= {i_row[3:0], i_col[7:0]};
    end else begin
      o_pix <= ~o_pix;
    end
  end
endmodule // sensor_array_model

// ==== exposure_trigger_readout_bench.sv ====
`timescale 1ns/1ps
module exposure_trigger_readout_bench;
  import exposure_trigger_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wr_data = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_trigger = 1'b0;
  logic [COORD_W-1:0] i_temp = 12'h100;
  logic [ADC_W-1:0] i_pix_data;
  logic [DATA_W-1:0] o_rd_data;
  logic [COORD_W-1:0] o_sensor_row;
  logic [COORD_W-1:0] o_sensor_col;
  logic [ADC_W-1:0] o_pix_data;
  logic o_exposing;
  logic o_sensor_read;
  logic o_line_valid;
  logic o_frame_valid;
  logic o_led_red;
  logic o_irq;
  int n_fail = 0;
  int samples_checked = 0;
  int exp_run = 0;
  int exp_last = 0;
  always #2 i_clk_sys = ~i_clk_sys;
  // measures each exposure whole, even one that starts while the last frame is still draining
  always @(posedge i_clk_sys) begin
    if (o_exposing === 1'b1) begin
      exp_run <= exp_run + 1;
    end else begin
      if (exp_run != 0) exp_last <= exp_run;
      exp_run <= 0;
    end
  end
  // small sensor and short indicator period keep the run short
  exposure_trigger_readout #(.SENSOR_COLS(12'h100), .SENSOR_ROWS(12'h004), .LINE_GAP(12'h002),
    .LED_HALF_CYCLES(4)) DUT (.i_clk_sys, .i_rst, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
    .i_trigger, .i_pix_data, .i_temp, .o_exposing, .o_sensor_read, .o_sensor_row, .o_sensor_col,
    .o_line_valid, .o_frame_valid, .o_pix_data, .o_led_red, .o_irq);
  sensor_array_model sensor (.i_clk_sys, .i_read(o_sensor_read), .i_row(o_sensor_row),
    .i_col(o_sensor_col), .o_pix(i_pix_data));
  ////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    tick();
    i_wr <= 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    tick();
    i_rd <= 1'b0;
    tick();
    d = o_rd_data;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  function automatic logic [7:0] lutv(input logic [11:0] c);
    return c[7:0] ^ {c[11:8], c[11:8]};
  endfunction
  task automatic wait_exp();
    int n = 0;
    while (o_exposing !== 1'b1 && n < 3000) begin tick(); n++; end
    chk("exposure start", 1, o_exposing);
  endtask
  task automatic expo_len(output int len);
    wait_exp();
    while (o_exposing === 1'b1) tick();
    tick();
    len = exp_last;
  endtask
  task automatic capture(input int x, input int y, input int w, input int h, input bit lut);
    int px = 0;
    int ln = 0;
    int n = 0;
    logic [11:0] raw;
    while (o_frame_valid !== 1'b1 && n < 3000) begin tick(); n++; end
    chk("frame start", 1, o_frame_valid);
    while (o_frame_valid === 1'b1) begin
      if (o_line_valid === 1'b1) begin
        raw = {4'(y + ln), 8'(x + px)};
        chk("pixel", lut ? {24'h000000, lutv(raw)} : {20'h00000, raw}, {20'h00000, o_pix_data});
        px++;
      end else if (px != 0) begin
        chk("line width", w, px);
        ln++;
        px = 0;
      end
      tick();
    end
    chk("last line width", w, px);
    chk("line count", h, ln + 1);
  endtask
  task automatic halt();
    logic [31:0] s;
    int n = 0;
    wr(REG_CTRL, 32'h0000_0000);
    do begin rd(REG_STATUS, s); n++; end while (s[4:0] != 5'h00 && n < 1000);
    chk("idle after stop", 0, s[4:0]);
  endtask
  task automatic pulse(input int p, output int len, output int gap);
    int lat = 0;
    len = 0;
    gap = 0;
    i_trigger <= 1'b1;
    repeat (p) begin
      tick();
      lat += (o_exposing !== 1'b1 && len == 0);
      len += (o_exposing === 1'b1);
    end
    chk("trigger latency", 1, lat > TRIG_LATENCY_CYC && lat <= TRIG_LATENCY_CYC + 2);
    i_trigger <= 1'b0;
    do begin tick(); len += (o_exposing === 1'b1); end while (o_exposing === 1'b1);
    while (o_sensor_read !== 1'b1 && gap < 500) begin tick(); gap++; end
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rchk("ctrl reset", REG_CTRL, 32'h0000_0000);
    rchk("exposure reset", REG_EXPOSURE, 32'h0000_2710);
    rchk("delay reset", REG_RD_DELAY, 32'h0000_0000);
    rchk("limit reset", REG_TEMP_LIMIT, 32'h0000_0C00);
    rchk("mask reset", REG_IRQ_MASK, 32'h0000_0000);
    wr(8'hFC, 32'hFFFF_FFFF);
    rchk("unmapped", 8'hFC, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_lut();
    wr(REG_LUT_ADDR, 32'h0000_0000);
    for (int i = 0; i < (1 << ADC_W); i++) wr(REG_LUT_DATA, {24'h000000, lutv(12'(i))});
    wr(REG_LUT_ADDR, 32'h0000_0FFF);
    rchk("last entry", REG_LUT_DATA, {24'h000000, lutv(12'hFFF)});
    $display("test table done");
  endtask
  task automatic t_free();
    int len;
    wr(REG_EXPOSURE, 32'h0000_0014);
    wr(REG_ROI_OFFSET, 32'h0003_000D);
    wr(REG_ROI_SIZE, 32'h0003_008F);
    wr(REG_CTRL, 32'h0000_000E);
    expo_len(len);
    chk("free exposure", 20, len);
    capture(8, 2, 136, 2, 1);
    expo_len(len);
    chk("next free exposure", 20, len);
    halt();
    wr(REG_ROI_SIZE, 32'h0001_0010);
    wr(REG_EXPOSURE, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_000C);
    capture(8, 2, 128, 2, 0);
    halt();
    $display("test free run done");
  endtask
  task automatic t_pulse();
    int l1, l2, g1, g2;
    wr(REG_CTRL, 32'h0000_0009);
    pulse(30, l1, g1);
    capture(0, 0, 256, 4, 0);
    wr(REG_RD_DELAY, 32'h0000_0028);
    pulse(50, l2, g2);
    chk("exposure follows pulse", 20, l2 - l1);
    chk("readout delay", 40, g2 - g1);
    capture(0, 0, 256, 4, 0);
    wr(REG_RD_DELAY, 32'h0000_0000);
    $display("test pulse done");
  endtask
  task automatic t_overlap();
    int l, g;
    int since = 0;
    logic early = 1'b0;
    pulse(30, l, g);
    while (o_line_valid !== 1'b1) tick();
    i_trigger <= 1'b1;
    while (o_line_valid === 1'b1) begin tick(); early |= (o_exposing === 1'b1); end
    while (o_exposing !== 1'b1 && since < 50) begin tick(); since++; end
    chk("no exposure inside line", 0, early);
    chk("exposure on line end", 1, since >= 1 && since <= 2);
    while (o_frame_valid === 1'b1) tick();
    tick(10);
    i_trigger <= 1'b0;
    capture(0, 0, 256, 4, 0);
    $display("test overlap done");
  endtask
  task automatic t_sw_irq();
    wr(REG_IRQ_STATUS, 32'h0000_0007);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    wr(REG_SW_TRIG, 32'h0000_0001);
    wait_exp();
    tick(20);
    wr(REG_SW_TRIG, 32'h0000_0000);
    capture(0, 0, 256, 4, 0);
    tick(3);
    chk("irq after frame", 1, o_irq);
    rchk("irq status", REG_IRQ_STATUS, 32'h0000_0003);
    wr(REG_IRQ_STATUS, 32'h0000_0001);
    tick(2);
    chk("irq cleared or masked", 0, o_irq);
    wr(REG_IRQ_MASK, 32'h0000_0002);
    tick(2);
    chk("irq unmasked", 1, o_irq);
    wr(REG_IRQ_STATUS, 32'h0000_0002);
    wr(REG_IRQ_MASK, 32'h0000_0000);
    $display("test soft trigger done");
  endtask
  task automatic t_temp();
    int n = 0;
    i_temp <= 12'h0AB;
    tick(4);
    rchk("temperature", REG_TEMP, 32'h0000_00AB);
    chk("led idle", 0, o_led_red);
    wr(REG_IRQ_MASK, 32'h0000_0004);
    i_temp <= 12'hC00;
    while (o_led_red !== 1'b1 && n < 20) begin tick(); n++; end
    n = 0;
    while (o_led_red === 1'b1 && n < 20) begin tick(); n++; end
    chk("led half period", 4, n);
    chk("temp irq", 1, o_irq);
    i_temp <= 12'h100;
    tick(6);
    chk("led off", 0, o_led_red);
    $display("test temperature done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tick(6);
    i_rst <= 1'b0;
    tick();
    t_regs();
    t_lut();
    t_free();
    t_pulse();
    t_overlap();
    t_sw_irq();
    t_temp();
    print_verdict();
  end
  // whole sequence needs about 15000 cycles
  initial begin
    tick(80000);
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule // exposure_trigger_readout_bench
bind exposure_trigger_readout exposure_trigger_sva u_sva (.i_clk_sys, .i_rst, .i_addr, .i_wr_data,
  .i_wr, .i_trigger, .i_temp, .o_exposing, .o_sensor_read, .o_line_valid, .o_frame_valid,
  .o_pix_data, .o_led_red);
